// file: ssc_defs.svh
// Operation
// - Checksum register bits 15..0 hold CRC-16-CCITT over settings; resets to all ones.
// - First checksum bit sits in the LSB, sixteenth in the MSB.
// - Status bit 12 is one on converter self-diagnostic failure, else zero.
// - Bits 11 and 10 flag abnormal current sink on inputs three and two.
// - Bits 9 and 8 flag abnormal current source on inputs one and zero.
// - Bits 7..6 give supply window b: 0 below, 1 between, 2 above; 3 unused.
// - Bits 5..4 give supply window a with the same three-state encoding.
// - Bit 3 is one while supply is below the undervoltage threshold.
// - Bit 2 is one while supply is above the overvoltage threshold.
// - Bit 1 is one while junction temperature exceeds the warning threshold.
// - Bit 0 is one while junction temperature exceeds the shutdown threshold.
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define SSC_OFF_CHECKSUM   6'h03
`define SSC_OFF_MISC       6'h04
`define SSC_ADDR_W         6
`define SSC_DATA_W         24

// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define SSC_CRC_INIT       16'hFFFF
`define SSC_CRC_POLY       16'h1021
`define SSC_DATA_ZERO      24'h00_0000
`define SSC_CRC_HI         15
`define SSC_BIT_ADC        12
`define SSC_BIT_SINK3      11
`define SSC_BIT_SINK2      10
`define SSC_BIT_SRC1       9
`define SSC_BIT_SRC0       8
`define SSC_WIN_B_HI       7
`define SSC_WIN_B_LO       6
`define SSC_WIN_A_HI       5
`define SSC_WIN_A_LO       4
`define SSC_BIT_UV         3
`define SSC_BIT_OV         2
`define SSC_BIT_TW         1
`define SSC_BIT_TSD        0

`endif

// file: ssc_pkg.sv
package ssc_pkg;

  // ----------------------------------------
  // Supply window encoding
  // ----------------------------------------
  typedef enum logic [1:0] {
    SSC_WIN_BELOW   = 2'h0,
    SSC_WIN_BETWEEN = 2'h1,
    SSC_WIN_ABOVE   = 2'h2,
    SSC_WIN_UNUSED  = 2'h3
  } ssc_win_t;

  // ----------------------------------------
  // Miscellaneous status layout
  // ----------------------------------------
  typedef struct packed {
    logic [10:0] reserved;
    logic        adc_fault;
    logic        sink_fault_input_three;
    logic        sink_fault_input_two;
    logic        source_fault_input_one;
    logic        source_fault_input_zero;
    ssc_win_t    supply_window_b_state;
    ssc_win_t    supply_window_a_state;
    logic        undervoltage_flag;
    logic        overvoltage_flag;
    logic        thermal_warning_flag;
    logic        thermal_shutdown_flag;
  } ssc_misc_t;

endpackage

// file: ssc_crc16_step.sv
`timescale 1ns/100ps
`default_nettype none
`include "ssc_defs.svh"

module ssc_crc16_step #(
  parameter int WORD_W = 24
) (
  input  wire logic [15:0]       crc_in,
  input  wire logic [WORD_W-1:0] word_in,
  output logic      [15:0]       crc_out
);

  // ----------------------------------------
  // Bitwise CRC-16-CCITT, word MSB first
  // ----------------------------------------
  always_comb begin
    logic [15:0] c;
    c = crc_in;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      if (c[`SSC_CRC_HI] ^ word_in[i]) begin
        c = {c[14:0], 1'b0} ^ `SSC_CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    crc_out = c;
  end

endmodule
`default_nettype wire

// file: ssc_status_checksum_readback.sv
`timescale 1ns/100ps
`default_nettype none
`include "ssc_defs.svh"

module ssc_status_checksum_readback #(
  parameter int CFG_W = 24
) (
  input  wire logic                   sys_clk_in,
  input  wire logic                   resetn_in,
  input  wire logic                   cfg_restart_in,
  input  wire logic                   cfg_valid_in,
  input  wire logic [CFG_W-1:0]       cfg_word_in,
  input  wire logic                   rd_en_in,
  input  wire logic [`SSC_ADDR_W-1:0] rd_addr_in,
  input  wire logic                   wr_en_in,
  input  wire logic                   adc_diag_fault_in,
  input  wire logic                   sink_fault_input_three_in,
  input  wire logic                   sink_fault_input_two_in,
  input  wire logic                   source_fault_input_one_in,
  input  wire logic                   source_fault_input_zero_in,
  input  wire logic                   supply_b_lower_threshold_in,
  input  wire logic                   supply_b_upper_threshold_in,
  input  wire logic                   supply_a_lower_threshold_in,
  input  wire logic                   supply_a_upper_threshold_in,
  input  wire logic                   undervoltage_flag_in,
  input  wire logic                   overvoltage_flag_in,
  input  wire logic                   thermal_warning_flag_in,
  input  wire logic                   thermal_shutdown_flag_in,
  output logic      [`SSC_DATA_W-1:0] rd_data_out,
  output logic                        rd_valid_out
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic              [15:0]            crc;
  logic              [15:0]            next_crc;
  logic              [15:0]            step_crc;
  ssc_pkg::ssc_misc_t                  misc;
  ssc_pkg::ssc_misc_t                  next_misc;
  logic              [`SSC_DATA_W-1:0] next_rd_data;
  logic                                next_rd_valid;

  // ----------------------------------------
  // Checksum engine
  // ----------------------------------------
  ssc_crc16_step #(
    .WORD_W (CFG_W)
  ) u_step (
    .crc_in  (crc),
    .word_in (cfg_word_in),
    .crc_out (step_crc)
  );

  function automatic ssc_pkg::ssc_win_t win_code(input logic lower, input logic upper);
    if (upper) begin
      return ssc_pkg::SSC_WIN_ABOVE;
    end else if (lower) begin
      return ssc_pkg::SSC_WIN_BETWEEN;
    end
    return ssc_pkg::SSC_WIN_BELOW;
  endfunction

  always_comb begin
    next_crc = crc;
    if (cfg_restart_in) begin
      next_crc = `SSC_CRC_INIT;
    end else if (cfg_valid_in) begin
      next_crc = step_crc;
    end
  end

  // ----------------------------------------
  // Live status capture
  // ----------------------------------------
  always_comb begin
    next_misc                         = '0;
    next_misc.adc_fault               = adc_diag_fault_in;
    next_misc.sink_fault_input_three  = sink_fault_input_three_in;
    next_misc.sink_fault_input_two    = sink_fault_input_two_in;
    next_misc.source_fault_input_one  = source_fault_input_one_in;
    next_misc.source_fault_input_zero = source_fault_input_zero_in;
    next_misc.supply_window_b_state   = win_code(supply_b_lower_threshold_in,
                                                 supply_b_upper_threshold_in);
    next_misc.supply_window_a_state   = win_code(supply_a_lower_threshold_in,
                                                 supply_a_upper_threshold_in);
    next_misc.undervoltage_flag       = undervoltage_flag_in;
    next_misc.overvoltage_flag        = overvoltage_flag_in;
    next_misc.thermal_warning_flag    = thermal_warning_flag_in;
    next_misc.thermal_shutdown_flag   = thermal_shutdown_flag_in;
  end

  // ----------------------------------------
  // Read port, writes ignored
  // ----------------------------------------
  always_comb begin
    next_rd_data  = `SSC_DATA_ZERO;
    next_rd_valid = rd_en_in;
    if (rd_en_in) begin
      case (rd_addr_in)
        `SSC_OFF_CHECKSUM: begin
          next_rd_data = {8'h00, crc};
        end
        `SSC_OFF_MISC: begin
          next_rd_data = misc;
        end
        default: begin
          next_rd_data = `SSC_DATA_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      crc          <= `SSC_CRC_INIT;
      misc         <= '0;
      rd_data_out  <= `SSC_DATA_ZERO;
      rd_valid_out <= 1'b0;
    end else begin
      crc          <= next_crc;
      misc         <= next_misc;
      rd_data_out  <= next_rd_data;
      rd_valid_out <= next_rd_valid;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_misc_read;
    rd_en_in && rd_addr_in == `SSC_OFF_MISC;
  endsequence

  sequence s_crc_read;
    rd_en_in && rd_addr_in == `SSC_OFF_CHECKSUM;
  endsequence

  property p_crc_reset;
    !$past(resetn_in) |-> crc == `SSC_CRC_INIT && !rd_valid_out;
  endproperty
  a_crc_reset: assert property (@(posedge sys_clk_in) p_crc_reset)
    else $error("checksum not all ones after reset");

  property p_crc_restart_read;
    cfg_restart_in ##1 (s_crc_read and !cfg_valid_in) |=> rd_data_out == 24'h00_FFFF;
  endproperty
  a_crc_restart_read: assert property (p_crc_restart_read)
    else $error("checksum readback not initial value after restart");

  property p_crc_order;
    s_crc_read |=> rd_valid_out && rd_data_out[15:0] == $past(crc) && rd_data_out[23:16] == 8'h00;
  endproperty
  a_crc_order: assert property (p_crc_order)
    else $error("checksum readback order or upper bits wrong");

  property p_write_ignored;
    wr_en_in && !cfg_valid_in && !cfg_restart_in |=> $stable(crc);
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("write changed the checksum");

  property p_misc_faults;
    s_misc_read |=> rd_data_out[`SSC_BIT_ADC:`SSC_BIT_SRC0] ==
      {$past(adc_diag_fault_in, 2), $past(sink_fault_input_three_in, 2),
       $past(sink_fault_input_two_in, 2), $past(source_fault_input_one_in, 2),
       $past(source_fault_input_zero_in, 2)};
  endproperty
  a_misc_faults: assert property (p_misc_faults)
    else $error("diagnostic fault bits wrong");

  property p_win_b;
    s_misc_read |=> rd_data_out[`SSC_WIN_B_HI:`SSC_WIN_B_LO] ==
      ($past(supply_b_upper_threshold_in, 2) ? 2'h2 :
       $past(supply_b_lower_threshold_in, 2) ? 2'h1 : 2'h0);
  endproperty
  a_win_b: assert property (p_win_b)
    else $error("supply window b code wrong");

  property p_win_a;
    s_misc_read |=> rd_data_out[`SSC_WIN_A_HI:`SSC_WIN_A_LO] ==
      ($past(supply_a_upper_threshold_in, 2) ? 2'h2 :
       $past(supply_a_lower_threshold_in, 2) ? 2'h1 : 2'h0);
  endproperty
  a_win_a: assert property (p_win_a)
    else $error("supply window a code wrong");

  property p_uv_ov;
    s_misc_read |=> rd_data_out[`SSC_BIT_UV] == $past(undervoltage_flag_in, 2) &&
                    rd_data_out[`SSC_BIT_OV] == $past(overvoltage_flag_in, 2);
  endproperty
  a_uv_ov: assert property (p_uv_ov)
    else $error("voltage flag bits wrong");

  property p_thermal;
    s_misc_read |=> rd_data_out[`SSC_BIT_TW] == $past(thermal_warning_flag_in, 2) &&
                    rd_data_out[`SSC_BIT_TSD] == $past(thermal_shutdown_flag_in, 2);
  endproperty
  a_thermal: assert property (p_thermal)
    else $error("thermal flag bits wrong");

  property p_misc_reserved;
    s_misc_read |=> rd_data_out[23:13] == 11'h000;
  endproperty
  a_misc_reserved: assert property (p_misc_reserved)
    else $error("reserved status bits not zero");

  property p_unmapped;
    rd_en_in && rd_addr_in != `SSC_OFF_MISC && rd_addr_in != `SSC_OFF_CHECKSUM
      |=> rd_data_out == `SSC_DATA_ZERO;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_idle_read;
    !rd_en_in |=> !rd_valid_out && rd_data_out == `SSC_DATA_ZERO;
  endproperty
  a_idle_read: assert property (p_idle_read)
    else $error("read port not idle without a request");

endmodule
`default_nettype wire

// file: ssc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "ssc_defs.svh"

// ----------------------------------------
// Host side read master
// ----------------------------------------
module ssc_host_model (
  input  wire logic                   clk_in,
  input  wire logic [`SSC_DATA_W-1:0] rd_data_in,
  input  wire logic                   rd_valid_in,
  output var  logic                   rd_en_out,
  output var  logic [`SSC_ADDR_W-1:0] rd_addr_out
);
  initial begin
    rd_en_out   = 1'b0;
    rd_addr_out = 6'h2a;
  end

  // One-cycle request, answer taken at the edge that closes its data cycle
  // Idle address shows the inverse so a stale index is never reused
  // Reads back the register at address a, with its valid flag, for the caller's own comparison
  task automatic do_read(input logic [`SSC_ADDR_W-1:0] a, output logic [`SSC_DATA_W-1:0] d,
                         output logic v);
    @(posedge clk_in);
    rd_en_out   <= 1'b1;
    rd_addr_out <= a;
    @(posedge clk_in);
    rd_en_out   <= 1'b0;
    rd_addr_out <= ~a;
    @(posedge clk_in);
    d = rd_data_in;
    v = rd_valid_in;
  endtask
endmodule
`default_nettype wire

// file: ssc_status_checksum_readback_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "ssc_defs.svh"

module ssc_status_checksum_readback_bench;
  logic        sys_clk_in, resetn_in, cfg_restart_in, cfg_valid_in, rd_en_in, wr_en_in;
  logic        rd_valid_out;
  logic [23:0] cfg_word_in, rd_data_out;
  logic [5:0]  rd_addr_in;
  logic [12:0] st, sv;
  logic [31:0] seed;
  logic [15:0] crc_exp;
  int          n_fail   = 0;
  int          n_checks = 0;
  int          cycles   = 0;

  ssc_status_checksum_readback i_ssc_status_checksum_readback (
    .sys_clk_in, .resetn_in, .cfg_restart_in, .cfg_valid_in, .cfg_word_in, .rd_en_in,
    .rd_addr_in, .wr_en_in, .rd_data_out, .rd_valid_out,
    .adc_diag_fault_in(st[12]), .sink_fault_input_three_in(st[11]),
    .sink_fault_input_two_in(st[10]), .source_fault_input_one_in(st[9]),
    .source_fault_input_zero_in(st[8]), .supply_b_upper_threshold_in(st[7]),
    .supply_b_lower_threshold_in(st[6]), .supply_a_upper_threshold_in(st[5]),
    .supply_a_lower_threshold_in(st[4]), .undervoltage_flag_in(st[3]),
    .overvoltage_flag_in(st[2]), .thermal_warning_flag_in(st[1]),
    .thermal_shutdown_flag_in(st[0])
  );

  ssc_host_model i_ssc_host_model (
    .clk_in(sys_clk_in), .rd_data_in(rd_data_out), .rd_valid_in(rd_valid_out),
    .rd_en_out(rd_en_in), .rd_addr_out(rd_addr_in)
  );

  // ----------------------------------------
  // Expectations
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [23:0] w);
    logic fb;
    for (int i = 23; i >= 0; i--) begin
      fb = c[15] ^ w[i];
      c  = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction

  function automatic logic [1:0] win(input logic up, input logic lo);
    return up ? 2'h2 : (lo ? 2'h1 : 2'h0);
  endfunction

  function automatic logic [23:0] exp_misc(input logic [12:0] s);
    return {11'h000, s[12:8], win(s[7], s[6]), win(s[5], s[4]), s[3:0]};
  endfunction

  // ----------------------------------------
  // Compare and read tasks
  // ----------------------------------------
  task automatic check_val(input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic check_flag(input logic got);
    n_checks++;
    if (got !== 1'b1) begin
      n_fail++;
      $display("BAD t=%0t exp=%h got=%h", $time, 1'b1, got);
    end
  endtask

  task automatic rd_check(input logic [5:0] a, input logic [23:0] exp);
    logic [23:0] d;
    logic        v;
    i_ssc_host_model.do_read(a, d, v);
    check_flag(v);
    check_val(exp, d);
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Clock and timeout
  // ----------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 4000) begin
      n_fail++;
      complete_run();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    resetn_in = 1'b0;
    cfg_restart_in = 1'b0;
    cfg_valid_in = 1'b0;
    cfg_word_in = 24'h00_0000;
    wr_en_in = 1'b0;
    st = 13'h0000;
    seed = 32'h0000_529f;
    repeat (3) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    rd_check(`SSC_OFF_CHECKSUM, 24'h00_FFFF);
    rd_check(`SSC_OFF_MISC, 24'h00_0000);
    $display("test reset values done");
    for (int r = 0; r < 3; r++) begin
      @(posedge sys_clk_in);
      cfg_restart_in <= 1'b1;
      crc_exp = 16'hFFFF;
      rd_check(`SSC_OFF_CHECKSUM, 24'h00_FFFF);
      for (int k = 0; k < 4 + r; k++) begin
        @(posedge sys_clk_in);
        seed = xs(seed);
        cfg_restart_in <= 1'b0;
        cfg_valid_in <= 1'b1;
        cfg_word_in <= seed[23:0];
        crc_exp = crc_step(crc_exp, seed[23:0]);
      end
      @(posedge sys_clk_in);
      cfg_valid_in <= 1'b0;
      rd_check(`SSC_OFF_CHECKSUM, {8'h00, crc_exp});
    end
    @(posedge sys_clk_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    rd_check(`SSC_OFF_CHECKSUM, 24'h00_FFFF);
    @(posedge sys_clk_in);
    cfg_restart_in <= 1'b1;
    cfg_valid_in <= 1'b1;
    @(posedge sys_clk_in);
    cfg_restart_in <= 1'b0;
    cfg_valid_in <= 1'b0;
    rd_check(`SSC_OFF_CHECKSUM, 24'h00_FFFF);
    $display("test checksum done");
    for (int i = 0; i < 20; i++) begin
      seed = xs(seed);
      sv = (i == 0) ? 13'h1fff : ((i == 1) ? 13'h0000 : seed[12:0]);
      @(posedge sys_clk_in);
      st <= sv;
      repeat (2) @(posedge sys_clk_in);
      rd_check(`SSC_OFF_MISC, exp_misc(sv));
    end
    $display("test status done");
    @(posedge sys_clk_in);
    wr_en_in <= 1'b1;
    rd_check(6'h00, 24'h00_0000);
    rd_check(6'h05, 24'h00_0000);
    rd_check(6'h3f, 24'h00_0000);
    rd_check(`SSC_OFF_CHECKSUM, 24'h00_FFFF);
    rd_check(`SSC_OFF_MISC, exp_misc(sv));
    wr_en_in <= 1'b0;
    $display("test read only done");
    complete_run();
  end
endmodule
`default_nettype wire
